// ===== common/pos_param_map.svh
// register indices, delivery values and timing constants of the parameter manager
`ifndef POS_PARAM_MAP_SVH
`define POS_PARAM_MAP_SVH

// ---------------------------------------------
// parameter indices
// ---------------------------------------------
`define IDX_ACT  8'h43
`define IDX_TMO  8'h76
`define IDX_DIR  8'h7b
`define IDX_NUM  8'h7c
`define IDX_DEN  8'h7d
`define IDX_REF  8'h7f
`define IDX_MAP  8'h80
`define IDX_UP   8'h81
`define IDX_LO   8'h82
`define IDX_WIN  8'h83
`define IDX_LOOP 8'h84
`define IDX_THR  8'h85
`define IDX_CFG  8'h89
`define IDX_SAFE 8'h8a
`define IDX_SAVE 8'hc1

// ---------------------------------------------
// delivery values and limits
// ---------------------------------------------
`define RST_SCALE 14'h0190
`define SCALE_MIN 14'h0001
`define SCALE_MAX 14'h2710
`define RST_MAP   32'h0001_9000
`define RST_UP    32'h0001_8b50
`define RST_LO    32'h0000_04b0
`define RST_ZERO  32'h0000_0000
`define POS_LIM   64'sh0000_0000_1000_0000
`define STEPS_REV 64'sh0000_0000_0000_0190
`define NARROW_REV 64'sh0000_0000_0000_00fa
`define HALF_REV  64'sh0000_0000_0000_0080
`define REACT_CANCEL 8'h01
`define REACT_SAFE   8'h02

// ---------------------------------------------
// timing
// ---------------------------------------------
`define CLK_NS 50
`define MS_NS  1000000

`endif

// ===== common/pos_param_pkg.sv
// types shared by the parameter manager
package pos_param_pkg;

  // one parameter access from the master side
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  idx;
    logic [31:0] data;
  } param_req_t;

  // answer to an access, one cycle later
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] data;
  } param_rsp_t;

  typedef enum logic [1:0] {
    SAVE_IDLE = 2'b01,
    SAVE_BUSY = 2'b10
  } save_state_t;

endpackage

// ===== hdl/position_parameter_manager.sv
// parameter store, range checks, save handshake and link supervision
`timescale 1ns/100ps
`include "pos_param_map.svh"
module position_parameter_manager #(
  parameter int MS_CYCLES = `MS_NS / `CLK_NS
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire pos_param_pkg::param_req_t req,
  output pos_param_pkg::param_rsp_t     rsp_ff,
  input  wire logic                     telegram,
  input  wire logic                     link_present,
  input  wire logic signed [31:0]       phys_pos,
  input  wire logic signed [31:0]       target_pos,
  input  wire logic                     run_active,
  input  wire logic                     nv_done,
  output logic                          nv_start_ff,
  output logic                          drag_error_ff,
  output logic                          link_lost_ff,
  output logic                          run_permit_ff,
  output logic                          run_cancel_ff,
  output logic                          safe_drive_ff,
  output logic signed [31:0]            safe_pos_ff,
  output logic                          narrow_window_ff
);

  // ---------------------------------------------
  // stored parameters
  // ---------------------------------------------
  logic               dir_ff;
  logic [13:0]        num_ff, den_ff;
  logic signed [31:0] ref_ff, map_ff, up_ff, lo_ff;
  logic [31:0]        win_ff, loop_ff, thr_ff, tmo_ff;
  logic [7:0]         cfg_ff;
  logic               dir_n;
  logic [13:0]        num_n, den_n;
  logic signed [31:0] ref_n, map_n, up_n, lo_n;
  logic [31:0]        win_n, loop_n;
  logic               acc;
  logic signed [31:0] act_pos;
  logic signed [31:0] d_ref;
  logic [13:0]        w14;
  logic               save_go;
  pos_param_pkg::save_state_t save_ff;

  // offset turns the physical position into the actual position used for reads and the drag check
  assign act_pos = phys_pos + ref_ff;
  assign w14     = req.data[13:0];

  // value within the numeric range
  function automatic logic in_rng(input logic signed [63:0] v);
    in_rng = (v >= -`POS_LIM) && (v <= `POS_LIM);
  endfunction

  // position in steps seen by the drive: offset removed, scaled to raw steps
  function automatic logic int_ok(input logic signed [31:0] v,
                                  input logic signed [31:0] r,
                                  input logic [13:0]        n,
                                  input logic [13:0]        d);
    logic signed [63:0] t;
    t = ((64'(v) - 64'(r)) * $signed(64'(n))) / $signed(64'(d));
    int_ok = in_rng(64'(v)) && in_rng(t);
  endfunction

  // move a step value to a new scaling, keeping its physical meaning
  function automatic logic signed [31:0] rescale(input logic signed [31:0] v,
                                                 input logic [13:0]        on,
                                                 input logic [13:0]        od,
                                                 input logic [13:0]        nn,
                                                 input logic [13:0]        nd);
    logic signed [63:0] t;
    t = (64'(v) * $signed(64'(on)) * $signed(64'(nd)))
        / ($signed(64'(od)) * $signed(64'(nn)));
    rescale = $signed(t[31:0]);
  endfunction

  // ---------------------------------------------
  // write check and dependent values
  // ---------------------------------------------
  // everything is worked out here first so a refused write changes nothing
  always_comb begin
    dir_n  = dir_ff;
    num_n  = num_ff;
    den_n  = den_ff;
    ref_n  = ref_ff;
    map_n  = map_ff;
    up_n   = up_ff;
    lo_n   = lo_ff;
    win_n  = win_ff;
    loop_n = loop_ff;
    acc    = 1'b1;
    d_ref  = 32'sh0;
    if (req.idx == `IDX_ACT) begin
      // new offset = wanted actual minus physical position
      ref_n = req.data - phys_pos;
      d_ref = ref_n - ref_ff;
      up_n  = up_ff + d_ref;
      lo_n  = lo_ff + d_ref;
      map_n = map_ff + d_ref;
      acc   = int_ok(up_n, ref_n, num_ff, den_ff) &&
              int_ok(lo_n, ref_n, num_ff, den_ff) &&
              in_rng(64'($signed(req.data)));
    end else if (req.idx == `IDX_REF) begin
      ref_n = req.data;
      d_ref = ref_n - ref_ff;
      up_n  = up_ff + d_ref;
      lo_n  = lo_ff + d_ref;
      map_n = map_ff + d_ref;
      acc   = int_ok(up_n, ref_n, num_ff, den_ff) &&
              int_ok(lo_n, ref_n, num_ff, den_ff);
    end else if (req.idx == `IDX_UP) begin
      up_n = req.data;
      if ($signed(req.data) <= lo_ff) begin
        lo_n = req.data - 32'sh1;
      end
      acc = int_ok(up_n, ref_ff, num_ff, den_ff) &&
            int_ok(lo_n, ref_ff, num_ff, den_ff);
    end else if (req.idx == `IDX_LO) begin
      lo_n = req.data;
      acc  = int_ok(lo_n, ref_ff, num_ff, den_ff) &&
             ($signed(req.data) < up_ff);
    end else if (req.idx == `IDX_MAP) begin
      map_n = req.data;
      up_n  = `RST_UP;
      lo_n  = `RST_LO;
    end else if (req.idx == `IDX_DIR) begin
      dir_n = req.data[0];
      if (req.data[0] != dir_ff) begin
        ref_n = `RST_ZERO;
        map_n = `RST_MAP;
        up_n  = `RST_UP;
        lo_n  = `RST_LO;
      end
    end else if (req.idx == `IDX_NUM || req.idx == `IDX_DEN) begin
      if (req.idx == `IDX_NUM) begin
        num_n = w14;
      end else begin
        den_n = w14;
      end
      acc = (req.data[31:14] == 18'h0) && (w14 >= `SCALE_MIN)
            && (w14 <= `SCALE_MAX);
      if (acc) begin
        // offset, mapping end, limits, window and loop follow the new step size; threshold and safe position keep their values
        ref_n  = rescale(ref_ff, num_ff, den_ff, num_n, den_n);
        map_n  = rescale(map_ff, num_ff, den_ff, num_n, den_n);
        up_n   = rescale(up_ff, num_ff, den_ff, num_n, den_n);
        lo_n   = rescale(lo_ff, num_ff, den_ff, num_n, den_n);
        win_n  = rescale(win_ff, num_ff, den_ff, num_n, den_n);
        loop_n = rescale(loop_ff, num_ff, den_ff, num_n, den_n);
      end
    end else if (req.idx == `IDX_WIN) begin
      win_n = req.data;
    end else if (req.idx == `IDX_LOOP) begin
      loop_n = req.data;
    end else if (req.idx == `IDX_TMO || req.idx == `IDX_THR ||
                 req.idx == `IDX_CFG || req.idx == `IDX_SAFE ||
                 req.idx == `IDX_SAVE) begin
      acc = 1'b1;
    end else begin
      acc = 1'b0;
    end
  end

  // ---------------------------------------------
  // parameter registers
  // ---------------------------------------------
  // only an accepted write loads the new set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_ff  <= 1'b0;
      num_ff  <= `RST_SCALE;
      den_ff  <= `RST_SCALE;
      ref_ff  <= `RST_ZERO;
      map_ff  <= `RST_MAP;
      up_ff   <= `RST_UP;
      lo_ff   <= `RST_LO;
      win_ff  <= `RST_ZERO;
      loop_ff <= `RST_ZERO;
    end else if (req.wr && acc) begin
      dir_ff  <= dir_n;
      num_ff  <= num_n;
      den_ff  <= den_n;
      ref_ff  <= ref_n;
      map_ff  <= map_n;
      up_ff   <= up_n;
      lo_ff   <= lo_n;
      win_ff  <= win_n;
      loop_ff <= loop_n;
    end
  end

  // supervision and safety parameters have no side effects
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_ff      <= `RST_ZERO;
      tmo_ff      <= `RST_ZERO;
      cfg_ff      <= 8'h0;
      safe_pos_ff <= `RST_ZERO;
    end else if (req.wr) begin
      if (req.idx == `IDX_THR) begin
        thr_ff <= req.data;
      end else if (req.idx == `IDX_TMO) begin
        tmo_ff <= req.data;
      end else if (req.idx == `IDX_CFG) begin
        cfg_ff <= req.data[7:0];
      end else if (req.idx == `IDX_SAFE) begin
        safe_pos_ff <= req.data;
      end
    end
  end

  // ---------------------------------------------
  // nonvolatile save handshake
  // ---------------------------------------------
  assign save_go = req.wr && (req.idx == `IDX_SAVE) && (req.data == 32'h1);

  // a new request in the done cycle wins and keeps the save running
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      save_ff     <= pos_param_pkg::SAVE_IDLE;
      nv_start_ff <= 1'b0;
    end else begin
      nv_start_ff <= save_go;
      case (save_ff)
        pos_param_pkg::SAVE_IDLE: begin
          if (save_go) begin
            save_ff <= pos_param_pkg::SAVE_BUSY;
          end
        end
        pos_param_pkg::SAVE_BUSY: begin
          if (nv_done && !save_go) begin
            save_ff <= pos_param_pkg::SAVE_IDLE;
          end
        end
        default: save_ff <= pos_param_pkg::SAVE_IDLE;
      endcase
    end
  end

  // ---------------------------------------------
  // read and answer
  // ---------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.ack  <= req.wr || req.rd;
      rsp_ff.err  <= req.wr && !acc;
      rsp_ff.data <= 32'h0;
      if (req.rd) begin
        rsp_ff.err <= 1'b0;
        if (req.idx == `IDX_ACT) begin
          rsp_ff.data <= act_pos;
        end else if (req.idx == `IDX_TMO) begin
          rsp_ff.data <= tmo_ff;
        end else if (req.idx == `IDX_DIR) begin
          rsp_ff.data <= {31'h0, dir_ff};
        end else if (req.idx == `IDX_NUM) begin
          rsp_ff.data <= {18'h0, num_ff};
        end else if (req.idx == `IDX_DEN) begin
          rsp_ff.data <= {18'h0, den_ff};
        end else if (req.idx == `IDX_REF) begin
          rsp_ff.data <= ref_ff;
        end else if (req.idx == `IDX_MAP) begin
          rsp_ff.data <= map_ff;
        end else if (req.idx == `IDX_UP) begin
          rsp_ff.data <= up_ff;
        end else if (req.idx == `IDX_LO) begin
          rsp_ff.data <= lo_ff;
        end else if (req.idx == `IDX_WIN) begin
          rsp_ff.data <= win_ff;
        end else if (req.idx == `IDX_LOOP) begin
          rsp_ff.data <= loop_ff;
        end else if (req.idx == `IDX_THR) begin
          rsp_ff.data <= thr_ff;
        end else if (req.idx == `IDX_CFG) begin
          rsp_ff.data <= {24'h0, cfg_ff};
        end else if (req.idx == `IDX_SAFE) begin
          rsp_ff.data <= safe_pos_ff;
        end else if (req.idx == `IDX_SAVE) begin
          rsp_ff.data <= {31'h0, save_ff == pos_param_pkg::SAVE_BUSY};
        end else begin
          rsp_ff.err <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------
  // drag error and power-up window
  // ---------------------------------------------
  logic signed [32:0] drag_d;
  logic signed [63:0] span;
  logic signed [63:0] mid_d;
  assign drag_d = 33'(target_pos) - 33'(act_pos);
  assign span   = 64'(up_ff) - 64'(lo_ff);
  assign mid_d  = (64'(act_pos) * 64'sh2) - 64'(up_ff) - 64'(lo_ff);

  // flag holds until the next run starts; a set in that cycle still wins
  logic run_d_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      drag_error_ff <= 1'b0;
      run_d_ff      <= 1'b0;
    end else begin
      run_d_ff <= run_active;
      if (run_active && ((drag_d < 0 ? -drag_d : drag_d) > $signed({1'b0, thr_ff}))) begin
        drag_error_ff <= 1'b1;
      end else if (run_active && !run_d_ff) begin
        drag_error_ff <= 1'b0;
      end
    end
  end

  // revolution counts compared in scaled steps to avoid a divider
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      narrow_window_ff <= 1'b1;
    end else begin
      narrow_window_ff <=
        (span * $signed(64'(num_ff)) <= `NARROW_REV * `STEPS_REV * $signed(64'(den_ff))) &&
        ((mid_d < 0 ? -mid_d : mid_d) * $signed(64'(num_ff))
          <= 64'sh2 * `HALF_REV * `STEPS_REV * $signed(64'(den_ff)));
    end
  end

  // ---------------------------------------------
  // link supervision
  // ---------------------------------------------
  logic [31:0] pre_ff;
  logic [31:0] ms_ff;
  logic        expired;
  assign expired = (tmo_ff != 32'h0) && (ms_ff >= tmo_ff);

  // every telegram restarts both the prescaler and the millisecond count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 32'h0;
      ms_ff  <= 32'h0;
    end else if (telegram) begin
      pre_ff <= 32'h0;
      ms_ff  <= 32'h0;
    end else if (pre_ff == 32'(MS_CYCLES - 1)) begin
      pre_ff <= 32'h0;
      if (!expired) begin
        ms_ff <= ms_ff + 32'h1;
      end
    end else begin
      pre_ff <= pre_ff + 32'h1;
    end
  end

  // reactions on loss: a zero timeout lets the running move finish
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_lost_ff  <= 1'b0;
      run_permit_ff <= 1'b0;
      run_cancel_ff <= 1'b0;
      safe_drive_ff <= 1'b0;
    end else begin
      link_lost_ff  <= !link_present || expired;
      run_permit_ff <= link_present && !expired;
      run_cancel_ff <= expired && run_active && (cfg_ff == `REACT_CANCEL);
      safe_drive_ff <= expired && (cfg_ff == `REACT_SAFE);
    end
  end

endmodule

// ===== sim/param_master_model.sv
// bus master model: indexed parameter accesses and keep-alive telegrams
`timescale 1ns/100ps
module param_master_model (
  input  wire logic                      ref_clk,
  input  wire pos_param_pkg::param_rsp_t rsp,
  output pos_param_pkg::param_req_t      req,
  output logic                           telegram
);
  logic alive = 1'b1;

  initial begin
    req = '0;
    telegram = 1'b0;
  end

  // telegrams stop while alive is low, so the supervision timer can run out
  always @(posedge ref_clk) begin
    telegram <= alive;
  end

  // request lasts one cycle; released lines carry the inverse, never a stale value
  task automatic acc(input logic w, input logic [7:0] i, input logic [31:0] d,
                     output logic e, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= '{wr: w, rd: !w, idx: i, data: d};
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b0, idx: ~i, data: ~d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 4);
    // a missing answer hands back unknowns, so every compare against it fails
    e = (rsp.ack === 1'b1) ? rsp.err : 1'bx;
    q = (rsp.ack === 1'b1) ? rsp.data : 'x;
  endtask
endmodule

// ===== sim/position_parameter_manager_sva.sv
// port-level assertions for the parameter manager
`timescale 1ns/100ps
`include "pos_param_map.svh"
module position_parameter_manager_sva #(
  parameter int MS_CYCLES = 4
) (
  input wire logic                      ref_clk,
  input wire logic                      rst_n,
  input wire pos_param_pkg::param_req_t req,
  input wire pos_param_pkg::param_rsp_t rsp_ff,
  input wire logic                      telegram,
  input wire logic                      link_present,
  input wire logic signed [31:0]        phys_pos,
  input wire logic signed [31:0]        target_pos,
  input wire logic                      run_active,
  input wire logic                      nv_done,
  input wire logic                      nv_start_ff,
  input wire logic                      drag_error_ff,
  input wire logic                      link_lost_ff,
  input wire logic                      run_permit_ff,
  input wire logic                      run_cancel_ff,
  input wire logic                      safe_drive_ff,
  input wire logic signed [31:0]        safe_pos_ff,
  input wire logic                      narrow_window_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------
  // parameter port, drag flag and link supervision
  // ---------------------------------------------
  req_answer_a: assert property ((req.wr || req.rd) |=> rsp_ff.ack)
    else $error("request left unanswered");
  scale_range_a: assert property (req.wr && (req.idx == `IDX_NUM || req.idx == `IDX_DEN)
    && (req.data == 32'h0 || req.data > 32'h2710) |=> rsp_ff.err)
    else $error("scale factor out of range accepted");
  limit_range_a: assert property (req.wr && ((req.idx == `IDX_UP &&
    $signed(req.data) > 32'sh1000_0000) || (req.idx == `IDX_LO &&
    $signed(req.data) < -32'sh1000_0000)) |=> rsp_ff.err)
    else $error("limit beyond numeric range accepted");
  save_start_a: assert property (nv_start_ff ==
    $past(req.wr && req.idx == `IDX_SAVE && req.data == 32'h1))
    else $error("save start not tied to a write of one");
  drag_run_a: assert property ($rose(drag_error_ff) |-> $past(run_active))
    else $error("drag flag raised outside a run");
  link_gone_a: assert property (!link_present |=> link_lost_ff && !run_permit_ff)
    else $error("missing link did not block new runs");
  cancel_cause_a: assert property (run_cancel_ff |-> link_lost_ff && $past(run_active)
    && !safe_drive_ff)
    else $error("cancel without expiry during a run");
  safe_cause_a: assert property (safe_drive_ff |-> link_lost_ff && !run_permit_ff)
    else $error("safe drive while link held");
  alive_link_a: assert property ((link_present && telegram)[*3] |=> !link_lost_ff)
    else $error("link lost despite steady telegrams");
  safe_store_a: assert property (req.wr && req.idx == `IDX_SAFE |=>
    safe_pos_ff == $past(req.data))
    else $error("safe position not stored");
endmodule

bind position_parameter_manager position_parameter_manager_sva #(.MS_CYCLES(MS_CYCLES)) chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rsp_ff(rsp_ff), .telegram(telegram),
  .link_present(link_present), .phys_pos(phys_pos), .target_pos(target_pos),
  .run_active(run_active), .nv_done(nv_done), .nv_start_ff(nv_start_ff),
  .drag_error_ff(drag_error_ff), .link_lost_ff(link_lost_ff), .run_permit_ff(run_permit_ff),
  .run_cancel_ff(run_cancel_ff), .safe_drive_ff(safe_drive_ff), .safe_pos_ff(safe_pos_ff),
  .narrow_window_ff(narrow_window_ff));

// ===== sim/position_parameter_manager_bench.sv
// self-checking bench for the parameter manager
`timescale 1ns/100ps
`include "pos_param_map.svh"
module position_parameter_manager_bench;
  logic                      ref_clk, rst_n, link_present, run_active, nv_done, telegram;
  logic signed [31:0]        phys_pos, target_pos, safe_pos_ff;
  pos_param_pkg::param_req_t req;
  pos_param_pkg::param_rsp_t rsp_ff;
  logic                      nv_start_ff, drag_error_ff, link_lost_ff, run_permit_ff;
  logic                      run_cancel_ff, safe_drive_ff, narrow_window_ff;
  int                        n_fail = 0, total_checks = 0, cyc = 0;

  // short millisecond keeps link expiry within a few dozen cycles
  position_parameter_manager #(.MS_CYCLES(4)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rsp_ff(rsp_ff), .telegram(telegram),
    .link_present(link_present), .phys_pos(phys_pos), .target_pos(target_pos),
    .run_active(run_active), .nv_done(nv_done), .nv_start_ff(nv_start_ff),
    .drag_error_ff(drag_error_ff), .link_lost_ff(link_lost_ff), .run_permit_ff(run_permit_ff),
    .run_cancel_ff(run_cancel_ff), .safe_drive_ff(safe_drive_ff), .safe_pos_ff(safe_pos_ff),
    .narrow_window_ff(narrow_window_ff));

  param_master_model mst (.ref_clk(ref_clk), .rsp(rsp_ff), .req(req), .telegram(telegram));

  // 50 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict;
    end
  end

  // ---------------------------------------------
  // shared helpers
  // ---------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic ee);
    logic e;
    logic [31:0] q;
    mst.acc(1'b1, i, d, e, q);
    chk($sformatf("error flag of write %h", i), {31'h0, ee}, {31'h0, e});
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] x);
    logic e;
    logic [31:0] q;
    mst.acc(1'b0, i, 32'h0, e, q);
    chk($sformatf("read of %h", i), x, q);
    chk($sformatf("read error of %h", i), 32'h0, {31'h0, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic bit_chk(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_reset;
    rd(`IDX_NUM, 32'h190);
    rd(`IDX_DEN, 32'h190);
    rd(`IDX_REF, 32'h0);
    rd(`IDX_MAP, 32'h1_9000);
    rd(`IDX_UP, 32'h1_8b50);
    rd(`IDX_LO, 32'h4b0);
    rd(`IDX_SAVE, 32'h0);
    wr(8'h00, 32'h1, 1'b1);
    $display("reset values done");
  endtask
  task automatic t_limits;
    wr(`IDX_UP, 32'h1388, 1'b0);
    wr(`IDX_LO, 32'h1388, 1'b1);
    wr(`IDX_LO, 32'h1387, 1'b0);
    wr(`IDX_UP, 32'hfa0, 1'b0);
    rd(`IDX_LO, 32'hf9f);
    wr(`IDX_UP, 32'h1000_0001, 1'b1);
    wr(`IDX_LO, 32'hefff_ffff, 1'b1);
    rd(`IDX_UP, 32'hfa0);
    wr(`IDX_UP, 32'h1000_0000, 1'b0);
    tick(2);
    bit_chk("wide range window", 1'b0, narrow_window_ff);
    $display("limit writes done");
  endtask
  task automatic t_map;
    phys_pos <= 32'sh3e8;
    wr(`IDX_MAP, 32'h1_c5e8, 1'b0);
    rd(`IDX_UP, 32'h1_8b50);
    rd(`IDX_LO, 32'h4b0);
    rd(`IDX_ACT, 32'h3e8);
    $display("mapping end done");
  endtask
  task automatic t_ref;
    wr(`IDX_ACT, 32'h12c, 1'b0);
    rd(`IDX_REF, 32'hffff_fd44);
    rd(`IDX_ACT, 32'h12c);
    rd(`IDX_UP, 32'h1_8894);
    rd(`IDX_LO, 32'h1f4);
    wr(`IDX_REF, 32'h1000_0000, 1'b1);
    rd(`IDX_REF, 32'hffff_fd44);
    $display("referencing done");
  endtask
  task automatic t_dir;
    wr(`IDX_DIR, 32'h1, 1'b0);
    rd(`IDX_REF, 32'h0);
    rd(`IDX_MAP, 32'h1_9000);
    rd(`IDX_UP, 32'h1_8b50);
    rd(`IDX_LO, 32'h4b0);
    bit_chk("narrow window", 1'b1, narrow_window_ff);
    $display("direction done");
  endtask
  task automatic t_scale;
    wr(`IDX_NUM, 32'h0, 1'b1);
    wr(`IDX_NUM, 32'h2711, 1'b1);
    wr(`IDX_DEN, 32'h2710, 1'b0);
    rd(`IDX_UP, 32'h26_9ad0);
    rd(`IDX_LO, 32'h7530);
    wr(`IDX_NUM, 32'h2710, 1'b0);
    rd(`IDX_UP, 32'h1_8b50);
    $display("scaling done");
  endtask
  task automatic t_save;
    wr(`IDX_SAVE, 32'h1, 1'b0);
    bit_chk("save start pulse", 1'b1, nv_start_ff);
    rd(`IDX_SAVE, 32'h1);
    nv_done <= 1'b1;
    tick(1);
    nv_done <= 1'b0;
    rd(`IDX_SAVE, 32'h0);
    $display("save done");
  endtask
  task automatic t_drag;
    wr(`IDX_THR, 32'ha, 1'b0);
    phys_pos <= 32'sh64;
    target_pos <= 32'sh6e;
    run_active <= 1'b1;
    tick(3);
    bit_chk("drag at threshold", 1'b0, drag_error_ff);
    target_pos <= 32'sh6f;
    tick(3);
    bit_chk("drag over threshold", 1'b1, drag_error_ff);
    run_active <= 1'b0;
    target_pos <= 32'sh64;
    tick(2);
    run_active <= 1'b1;
    tick(3);
    bit_chk("drag on new run", 1'b0, drag_error_ff);
    $display("drag done");
  endtask
  task automatic t_link;
    link_present <= 1'b0;
    tick(3);
    bit_chk("lost, no timeout", 1'b1, link_lost_ff);
    bit_chk("permit, no timeout", 1'b0, run_permit_ff);
    bit_chk("cancel, no timeout", 1'b0, run_cancel_ff);
    link_present <= 1'b1;
    wr(`IDX_TMO, 32'h2, 1'b0);
    wr(`IDX_CFG, 32'h1, 1'b0);
    bit_chk("permit with link", 1'b1, run_permit_ff);
    mst.alive <= 1'b0;
    tick(16);
    bit_chk("cancel on expiry", 1'b1, run_cancel_ff);
    bit_chk("permit on expiry", 1'b0, run_permit_ff);
    mst.alive <= 1'b1;
    run_active <= 1'b0;
    wr(`IDX_CFG, 32'h2, 1'b0);
    wr(`IDX_SAFE, 32'h1234, 1'b0);
    bit_chk("lost after restart", 1'b0, link_lost_ff);
    mst.alive <= 1'b0;
    tick(16);
    bit_chk("safe drive at rest", 1'b1, safe_drive_ff);
    chk("safe position", 32'h1234, safe_pos_ff);
    $display("link supervision done");
  endtask
  // parameters sent in the order that avoids automatic adjustment
  task automatic t_order;
    wr(`IDX_DIR, 32'h0, 1'b0);
    wr(`IDX_NUM, 32'h190, 1'b0);
    wr(`IDX_DEN, 32'h190, 1'b0);
    wr(`IDX_REF, 32'h64, 1'b0);
    wr(`IDX_MAP, 32'h1_9064, 1'b0);
    wr(`IDX_UP, 32'h1_8bb4, 1'b0);
    wr(`IDX_LO, 32'h514, 1'b0);
    wr(`IDX_WIN, 32'h5, 1'b0);
    wr(`IDX_LOOP, 32'h20, 1'b0);
    rd(`IDX_REF, 32'h64);
    rd(`IDX_MAP, 32'h1_9064);
    rd(`IDX_UP, 32'h1_8bb4);
    rd(`IDX_LO, 32'h514);
    wr(`IDX_DEN, 32'h320, 1'b0);
    rd(`IDX_WIN, 32'ha);
    rd(`IDX_LOOP, 32'h40);
    rd(`IDX_UP, 32'h3_1768);
    rd(`IDX_THR, 32'ha);
    rd(`IDX_TMO, 32'h2);
    $display("parameter order done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    link_present = 1'b1;
    run_active = 1'b0;
    nv_done = 1'b0;
    phys_pos = 32'sh0;
    target_pos = 32'sh0;
    tick(10);
    rst_n <= 1'b1;
    t_reset;
    t_limits;
    t_map;
    t_ref;
    t_dir;
    t_scale;
    t_save;
    t_drag;
    t_link;
    t_order;
    give_verdict;
  end
endmodule
